// ===== acc_pkg.sv
// Purpose: Shared constants, types and decode functions for the ADC config block
// Assumes: 32-bit AHB-Lite word access, one register per aligned word
// Notes: Byte address of a register is four times its index
package acc_pkg;
    // Register indices; byte address = index * 4
    localparam logic [7:0] IDX_CH2_A = 8'h05;
    localparam logic [7:0] IDX_CH2_B = 8'h06;
    localparam logic [7:0] IDX_T_A = 8'h08;
    localparam logic [7:0] IDX_T_B = 8'h09;
    localparam logic [7:0] IDX_START = 8'h0b;
    localparam logic [7:0] IDX_STATUS = 8'h0c;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    // Field positions in the configuration words
    localparam int GAIN_MSB = 15;
    localparam int GAIN_LSB = 11;
    localparam int CLK_MSB = 10;
    localparam int CLK_LSB = 8;
    localparam int RES_MSB = 6;
    localparam int RES_LSB = 4;
    localparam int OFS_SIGN = 3;
    localparam int MAG_MSB = 2;
    localparam int MAG_LSB = 0;
    localparam int BIAS_MSB = 6;
    localparam int BIAS_LSB = 4;
    localparam int REF_MSB = 1;
    localparam int REF_LSB = 0;
    localparam int START_CH2_BIT = 1;
    localparam int START_T_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_TEMP_BIT = 1;

    // Writable bits of each word; all others read zero
    localparam logic [15:0] CFG_A_MASK = 16'hff7f;
    localparam logic [15:0] CH2_B_MASK = 16'h0073;
    localparam logic [15:0] T_B_MASK = 16'h0070;
    localparam logic [15:0] CFG_RESET = 16'h0000;

    localparam logic [1:0] REF_SUPPLY = 2'b00;
    localparam logic [1:0] REF_EXTERNAL = 2'b01;
    localparam int REF_BANDGAP_BIT = 1;
    localparam logic [1:0] TEMP_REF_SEL = 2'b00;

    localparam logic [4:0] GAIN_MID_START = 5'h0a;
    localparam logic [4:0] GAIN_HIGH_START = 5'h14;
    localparam logic [8:0] HALF_BASE = 9'h002;
    localparam int DUR_W = 21;

    typedef enum logic {ACC_IDLE = 1'b0, ACC_RUN = 1'b1} acc_state_t;

    // Converter clocks per conversion for a resolution code
    function automatic logic [11:0] acc_cpc(input logic [2:0] code);
        case (code)
            3'h0: acc_cpc = 12'h100;
            3'h1: acc_cpc = 12'h140;
            3'h2: acc_cpc = 12'h200;
            3'h3: acc_cpc = 12'h280;
            3'h4: acc_cpc = 12'h320;
            3'h5: acc_cpc = 12'h500;
            default: acc_cpc = 12'h800;
        endcase
    endfunction : acc_cpc

    // Result width in bits for a resolution code
    function automatic logic [4:0] acc_res_bits(input logic [2:0] code);
        case (code)
            3'h0: acc_res_bits = 5'h09;
            3'h1: acc_res_bits = 5'h0a;
            3'h2: acc_res_bits = 5'h0c;
            3'h3: acc_res_bits = 5'h0d;
            3'h4: acc_res_bits = 5'h0e;
            3'h5: acc_res_bits = 5'h0f;
            default: acc_res_bits = 5'h10;
        endcase
    endfunction : acc_res_bits

    // Ticks in half a converter clock period
    function automatic logic [8:0] acc_half(input logic [2:0] code);
        acc_half = HALF_BASE << code;
    endfunction : acc_half

    // Offset scale group of a gain code
    function automatic logic [1:0] acc_gain_group(input logic [4:0] gain);
        if (gain >= GAIN_HIGH_START) acc_gain_group = 2'h2;
        else if (gain >= GAIN_MID_START) acc_gain_group = 2'h1;
        else acc_gain_group = 2'h0;
    endfunction : acc_gain_group
endpackage : acc_pkg

// ===== acc_clk_div.sv
// Purpose: Converter clock divided from the 4 MHz system tick
// Assumes: sys_tick is one core_clk pulse per 4 MHz period
// Notes: Clock starts low and restarts on every run
`timescale 1ns/1ps
module acc_clk_div
    import acc_pkg::*;
(
    input wire logic core_clk, // Core clock
    input wire logic rst, // Async reset
    input wire logic run, // Conversion in progress
    input wire logic sys_tick, // 4 MHz tick
    input wire logic [2:0] clock_code, // Divisor select
    output logic converter_clock, // Divided clock
    output logic period_end // Falling edge tick
);
    logic [8:0] cnt;
    logic last;

    assign last = run && sys_tick && (cnt == acc_half(clock_code) - 9'h001);
    assign period_end = last && converter_clock;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt <= 9'h000;
            converter_clock <= 1'b0;
        end else if (!run) begin
            cnt <= 9'h000;
            converter_clock <= 1'b0;
        end else if (last) begin
            cnt <= 9'h000;
            converter_clock <= !converter_clock;
        end else if (sys_tick) begin
            cnt <= cnt + 9'h001;
        end
    end
endmodule : acc_clk_div

// ===== acc_conv_timer.sv
// Purpose: Counts converter clock periods of one conversion
// Assumes: clocks_per_conv stays stable while run is high
// Notes: done is a one-cycle pulse on the last period end
`timescale 1ns/1ps
module acc_conv_timer
    import acc_pkg::*;
(
    input wire logic core_clk, // Core clock
    input wire logic rst, // Async reset
    input wire logic run, // Conversion in progress
    input wire logic period_end, // End of one converter clock
    input wire logic [11:0] clocks_per_conv, // Periods needed
    output logic done // Last period finished
);
    logic [11:0] periods;

    assign done = run && period_end && (periods == clocks_per_conv - 12'h001);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            periods <= 12'h000;
        end else if (!run) begin
            periods <= 12'h000;
        end else if (period_end) begin
            periods <= periods + 12'h001;
        end
    end
endmodule : acc_conv_timer

// ===== acc_top.sv
// Purpose: ADC channel-2 and temperature configuration with conversion timing
// Assumes: AHB-Lite single word transfers; sys_tick marks the 4 MHz system clock
// Notes: Reads take one wait state, writes none
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
(
    input wire logic core_clk, // 50 MHz clock
    input wire logic rst, // Async reset, high
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    input wire logic sys_tick, // 4 MHz tick
    output logic cpu_halt, // CPU held during conversion
    output logic conv_done, // Conversion finished pulse
    output logic conv_temp, // Active channel is temperature
    output logic [4:0] adc_gain_code, // Amplifier gain
    output logic [1:0] adc_gain_group, // Offset scale group
    output logic [2:0] adc_clock_code, // Divisor select
    output logic [2:0] adc_resolution_code, // Resolution select
    output logic [4:0] adc_resolution_bits, // Result width
    output logic [11:0] adc_clocks_per_conv, // Periods per conversion
    output logic adc_offset_sign, // Offset subtracts
    output logic [2:0] adc_offset_magnitude, // Offset size
    output logic signed [3:0] adc_offset_level, // Ordered offset step
    output logic [2:0] adc_bias_code, // Bias setting
    output logic [1:0] adc_reference_select, // Reference code
    output logic ref_supply, // Supply reference
    output logic ref_external, // Twice external reference
    output logic ref_bandgap, // Four times bandgap
    output logic converter_clock // Divided converter clock
);
    acc_state_t state;
    logic [15:0] chan2_gain_clock_res_offset;
    logic [15:0] chan2_bias_reference;
    logic [15:0] temp_gain_clock_res_offset;
    logic [15:0] temp_bias;
    logic chan2_convert_start;
    logic temp_convert_start;
    logic addr_ok;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] dp_idx;
    logic busy;
    logic launch;
    logic done;
    logic period_end;
    logic [15:0] sel_a;
    logic [15:0] sel_b;
    logic [1:0] sel_ref;
    logic wr_cfg;

    function automatic logic [31:0] read_value(input logic [7:0] idx);
        read_value = 32'h0000_0000;
        unique case (idx)
            IDX_CH2_A: read_value[15:0] = chan2_gain_clock_res_offset;
            IDX_CH2_B: read_value[15:0] = chan2_bias_reference;
            IDX_T_A: read_value[15:0] = temp_gain_clock_res_offset;
            IDX_T_B: read_value[15:0] = temp_bias;
            IDX_START: begin
                read_value[START_CH2_BIT] = chan2_convert_start;
                read_value[START_T_BIT] = temp_convert_start;
            end
            IDX_STATUS: begin
                read_value[STAT_BUSY_BIT] = busy;
                read_value[STAT_TEMP_BIT] = conv_temp;
            end
            default: read_value = 32'h0000_0000;
        endcase
    endfunction : read_value

    assign busy = (state == ACC_RUN);
    assign addr_ok = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
    assign hreadyout = !rd_pend;
    assign hresp = HRESP_OKAY;
    assign launch = !busy && (chan2_convert_start || temp_convert_start);
    assign wr_cfg = wr_pend && !busy;

    // Bus address and data phase tracking
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            dp_idx <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite;
            rd_pend <= addr_ok && !hwrite;
            if (addr_ok) begin
                dp_idx <= haddr[IDX_MSB:IDX_LSB];
            end
        end
    end

    // Read data loaded in the wait state, after any earlier write landed
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend) begin
            hrdata <= read_value(dp_idx);
        end
    end

    // Configuration words; unused bits masked on write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chan2_gain_clock_res_offset <= CFG_RESET;
            chan2_bias_reference <= CFG_RESET;
            temp_gain_clock_res_offset <= CFG_RESET;
            temp_bias <= CFG_RESET;
        end else if (wr_pend) begin
            unique case (dp_idx)
                IDX_CH2_A: chan2_gain_clock_res_offset <= hwdata[15:0] & CFG_A_MASK;
                IDX_CH2_B: chan2_bias_reference <= hwdata[15:0] & CH2_B_MASK;
                IDX_T_A: temp_gain_clock_res_offset <= hwdata[15:0] & CFG_A_MASK;
                IDX_T_B: temp_bias <= hwdata[15:0] & T_B_MASK;
                default: ;
            endcase
        end
    end

    // Start bits: set by software while idle, cleared at completion
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chan2_convert_start <= 1'b0;
            temp_convert_start <= 1'b0;
        end else if (done) begin
            chan2_convert_start <= 1'b0;
            temp_convert_start <= 1'b0;
        end else if (wr_cfg && dp_idx == IDX_START) begin
            chan2_convert_start <= hwdata[START_CH2_BIT];
            temp_convert_start <= hwdata[START_T_BIT];
        end
    end

    // Conversion sequence
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= ACC_IDLE;
        end else begin
            unique case (state)
                ACC_IDLE: if (launch) state <= ACC_RUN;
                ACC_RUN: if (done) state <= ACC_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cpu_halt <= 1'b0;
            conv_done <= 1'b0;
        end else begin
            cpu_halt <= launch || (busy && !done);
            conv_done <= done;
        end
    end

    // Channel 2 wins when both start bits are set
    assign sel_a = chan2_convert_start ? chan2_gain_clock_res_offset : temp_gain_clock_res_offset;
    assign sel_b = chan2_convert_start ? chan2_bias_reference : temp_bias;
    assign sel_ref = chan2_convert_start ? sel_b[REF_MSB:REF_LSB] : TEMP_REF_SEL;

    // Settings applied to the converter for the whole conversion
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            conv_temp <= 1'b0;
            adc_gain_code <= 5'h00;
            adc_gain_group <= 2'h0;
            adc_clock_code <= 3'h0;
            adc_resolution_code <= 3'h0;
            adc_resolution_bits <= 5'h00;
            adc_clocks_per_conv <= 12'h000;
            adc_offset_sign <= 1'b0;
            adc_offset_magnitude <= 3'h0;
            adc_offset_level <= 4'sh0;
            adc_bias_code <= 3'h0;
            adc_reference_select <= 2'h0;
            ref_supply <= 1'b0;
            ref_external <= 1'b0;
            ref_bandgap <= 1'b0;
        end else if (launch) begin
            conv_temp <= !chan2_convert_start;
            adc_gain_code <= sel_a[GAIN_MSB:GAIN_LSB];
            adc_gain_group <= acc_gain_group(sel_a[GAIN_MSB:GAIN_LSB]);
            adc_clock_code <= sel_a[CLK_MSB:CLK_LSB];
            adc_resolution_code <= sel_a[RES_MSB:RES_LSB];
            adc_resolution_bits <= acc_res_bits(sel_a[RES_MSB:RES_LSB]);
            adc_clocks_per_conv <= acc_cpc(sel_a[RES_MSB:RES_LSB]);
            adc_offset_sign <= sel_a[OFS_SIGN];
            adc_offset_magnitude <= sel_a[MAG_MSB:MAG_LSB];
            adc_offset_level <= sel_a[OFS_SIGN] ? ~{1'b0, sel_a[MAG_MSB:MAG_LSB]}
                : {1'b0, sel_a[MAG_MSB:MAG_LSB]};
            adc_bias_code <= sel_b[BIAS_MSB:BIAS_LSB];
            adc_reference_select <= sel_ref;
            ref_supply <= (sel_ref == REF_SUPPLY);
            ref_external <= (sel_ref == REF_EXTERNAL);
            ref_bandgap <= sel_ref[REF_BANDGAP_BIT];
        end
    end

    acc_clk_div u_clk_div (
        .core_clk(core_clk),
        .rst(rst),
        .run(busy),
        .sys_tick(sys_tick),
        .clock_code(adc_clock_code),
        .converter_clock(converter_clock),
        .period_end(period_end)
    );

    acc_conv_timer u_conv_timer (
        .core_clk(core_clk),
        .rst(rst),
        .run(busy),
        .period_end(period_end),
        .clocks_per_conv(adc_clocks_per_conv),
        .done(done)
    );

    // Helpers read only by the checks below
    logic [DUR_W-1:0] dur_ticks;
    logic [8:0] half_ticks;
    logic clk_q;
    logic [DUR_W-1:0] dur_expect;

    assign dur_expect = DUR_W'(adc_clocks_per_conv) * DUR_W'(acc_half(adc_clock_code))
        * DUR_W'(2);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dur_ticks <= '0;
        end else if (!busy) begin
            dur_ticks <= '0;
        end else if (sys_tick) begin
            dur_ticks <= dur_ticks + DUR_W'(1);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            half_ticks <= 9'h000;
            clk_q <= 1'b0;
        end else begin
            clk_q <= converter_clock;
            if (!busy) half_ticks <= 9'h000;
            else if (clk_q != converter_clock) half_ticks <= {8'h00, sys_tick};
            else if (sys_tick) half_ticks <= half_ticks + 9'h001;
        end
    end

    sequence s_start_write;
        wr_pend && !busy && dp_idx == IDX_START && hwdata[START_CH2_BIT];
    endsequence

    sequence s_launch_ch2;
        ##1 chan2_convert_start ##1 (busy && cpu_halt && !conv_temp);
    endsequence

    sequence s_launch_cfg;
        !busy ##1 busy;
    endsequence

    a_ch2_gain_clock: assert property (@(posedge core_clk) disable iff (rst)
        s_launch_cfg ##0 !conv_temp
        |-> adc_gain_code == $past(chan2_gain_clock_res_offset[GAIN_MSB:GAIN_LSB])
        && adc_clock_code == $past(chan2_gain_clock_res_offset[CLK_MSB:CLK_LSB]))
        else $error("Channel 2 gain or clock code not applied");

    a_ch2_res_offset: assert property (@(posedge core_clk) disable iff (rst)
        $rose(busy) && !conv_temp |-> adc_resolution_code == $past(chan2_gain_clock_res_offset[RES_MSB:RES_LSB])
        && adc_offset_sign == $past(chan2_gain_clock_res_offset[OFS_SIGN]))
        else $error("Channel 2 resolution or offset not applied");

    a_ch2_bias_ref: assert property (@(posedge core_clk) disable iff (rst)
        $rose(busy) && !conv_temp |-> adc_bias_code == $past(chan2_bias_reference[BIAS_MSB:BIAS_LSB])
        && adc_reference_select == $past(chan2_bias_reference[REF_MSB:REF_LSB]))
        else $error("Channel 2 bias or reference not applied");

    a_temp_fields: assert property (@(posedge core_clk) disable iff (rst)
        $rose(busy) && conv_temp |-> adc_gain_code == $past(temp_gain_clock_res_offset[GAIN_MSB:GAIN_LSB])
        && adc_bias_code == $past(temp_bias[BIAS_MSB:BIAS_LSB]) && adc_reference_select == TEMP_REF_SEL)
        else $error("Temperature settings not applied");

    a_clk_half_period: assert property (@(posedge core_clk) disable iff (rst)
        busy && $past(busy) && clk_q != converter_clock |-> half_ticks == acc_half(adc_clock_code))
        else $error("Converter clock half period wrong");

    a_res_table: assert property (@(posedge core_clk) disable iff (rst)
        busy |-> adc_clocks_per_conv == acc_cpc(adc_resolution_code)
        && adc_resolution_bits == acc_res_bits(adc_resolution_code))
        else $error("Resolution table mismatch");

    a_conv_length: assert property (@(posedge core_clk) disable iff (rst)
        done |-> dur_ticks + DUR_W'(1) == dur_expect)
        else $error("Conversion length wrong");

    a_offset_level: assert property (@(posedge core_clk) disable iff (rst)
        busy |-> (adc_offset_level < 0) == adc_offset_sign)
        else $error("Offset sign not applied");

    a_start_launch: assert property (@(posedge core_clk) disable iff (rst)
        s_start_write |-> s_launch_ch2)
        else $error("Start bit did not launch channel 2");

    a_start_clear: assert property (@(posedge core_clk) disable iff (rst)
        done |=> !chan2_convert_start && !temp_convert_start && conv_done && !cpu_halt)
        else $error("Start bit not cleared at completion");

    a_ref_decode: assert property (@(posedge core_clk) disable iff (rst)
        busy |-> $onehot({ref_supply, ref_external, ref_bandgap})
        && ref_bandgap == adc_reference_select[REF_BANDGAP_BIT])
        else $error("Reference decode wrong");

    a_unused_zero: assert property (@(posedge core_clk) disable iff (rst)
        $past(rd_pend) && $past(dp_idx) == IDX_CH2_B |-> hrdata[31:7] == 25'h0 && hrdata[3:2] == 2'h0)
        else $error("Unused bits read nonzero");
endmodule : acc_top

// ===== acc_cpu_model.sv
// Purpose: CPU-side AHB-Lite master issuing single word transfers
// Assumes: one slave, its hreadyout is the bus hready
// Notes: xfer is entered right after a rising edge
`timescale 1ns/1ps
module acc_cpu_model (
    input wire logic core_clk, // Clock
    input wire logic hready, // Bus ready
    input wire logic [31:0] hrdata, // Read data
    output logic hsel, // Select
    output logic [31:0] haddr, // Byte address
    output logic [1:0] htrans, // Transfer type
    output logic hwrite, // Write
    output logic [2:0] hsize, // Size
    output logic [31:0] hwdata // Write data
);
    initial begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    end

    // Address phase held until ready, then data phase held until ready
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge core_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : xfer
endmodule : acc_cpu_model

// ===== testbench.sv
// Purpose: Self-checking bench for the ADC configuration block
// Assumes: system tick every third core cycle
// Notes: one conversion per resolution code 0 to 6
`timescale 1ns/1ps
module testbench;
    import acc_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic sys_tick = 1'b0;
    logic [1:0] tdiv = 2'h0;
    logic hsel, hwrite, hreadyout, hresp, cpu_halt, conv_done, conv_temp, adc_offset_sign;
    logic ref_supply, ref_external, ref_bandgap, converter_clock;
    logic [1:0] htrans, adc_gain_group, adc_reference_select, rs;
    logic [2:0] hsize, adc_clock_code, adc_resolution_code, adc_offset_magnitude, adc_bias_code;
    logic [4:0] adc_gain_code, adc_resolution_bits;
    logic [11:0] adc_clocks_per_conv;
    logic signed [3:0] adc_offset_level;
    logic [31:0] haddr, hwdata, hrdata, q;
    int n_mismatch = 0;
    int checks = 0;
    int seed = 32'h466e;
    logic [4:0] gains [17] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
        5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h14, 5'h18, 5'h1c, 5'h1e};
    int cpc_t [7] = '{256, 320, 512, 640, 800, 1280, 2048};
    int bits_t [7] = '{9, 10, 12, 13, 14, 15, 16};

    acc_top acc_top_i (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sys_tick, .cpu_halt, .conv_done,
        .conv_temp, .adc_gain_code, .adc_gain_group, .adc_clock_code, .adc_resolution_code,
        .adc_resolution_bits, .adc_clocks_per_conv, .adc_offset_sign, .adc_offset_magnitude,
        .adc_offset_level, .adc_bias_code, .adc_reference_select, .ref_supply, .ref_external,
        .ref_bandgap, .converter_clock);
    acc_cpu_model acc_cpu_model_i (.core_clk, .hready(hreadyout), .hrdata, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata);

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        tdiv <= (tdiv == 2'h2) ? 2'h0 : tdiv + 2'h1;
        sys_tick <= (tdiv == 2'h0);
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    function automatic logic [1:0] grp(input logic [4:0] g);
        return (g >= 5'h14) ? 2'h2 : (g >= 5'h0a) ? 2'h1 : 2'h0;
    endfunction : grp

    function automatic logic [3:0] lvl(input logic [3:0] c);
        return c[3] ? 4'h0 - {1'b0, c[2:0]} - 4'h1 : {1'b0, c[2:0]};
    endfunction : lvl

    task automatic regs();
        logic [7:0] idx [4] = '{IDX_CH2_A, IDX_CH2_B, IDX_T_A, IDX_T_B};
        logic [15:0] msk [4] = '{16'hff7f, 16'h0073, 16'hff7f, 16'h0070};
        logic [31:0] d;
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            if (i < 4) begin
                acc_cpu_model_i.xfer(1'b0, idx[i], 32'h0, q);
                chk("reset", q, 32'h0);
            end
            acc_cpu_model_i.xfer(1'b1, idx[i % 4], d, q);
            acc_cpu_model_i.xfer(1'b0, idx[i % 4], 32'h0, q);
            chk("readback", q, {16'h0, d[15:0] & msk[i % 4]});
        end
        acc_cpu_model_i.xfer(1'b1, 8'h07, 32'hffffffff, q);
        acc_cpu_model_i.xfer(1'b0, 8'h07, 32'h0, q);
        chk("unmapped", q, 32'h0);
        chk("hresp", hresp, 1'b0);
    endtask : regs

    task automatic conv(input int r, input logic t, input logic [2:0] ck);
        logic [15:0] a;
        logic [15:0] b;
        int n;
        int w;
        a = {gains[$unsigned($random(seed)) % 17], ck, 1'b1, r[2:0], 4'($random(seed))};
        b = 16'($random(seed));
        if (!t && b[1:0] == 2'h0) b[0] = 1'b1;
        rs = t ? 2'h0 : b[1:0];
        acc_cpu_model_i.xfer(1'b1, t ? IDX_T_A : IDX_CH2_A, {16'hffff, a}, q);
        acc_cpu_model_i.xfer(1'b1, t ? IDX_T_B : IDX_CH2_B, {16'hffff, b}, q);
        // Both start bits on channel-2 runs: channel 2 must win
        acc_cpu_model_i.xfer(1'b1, IDX_START, t ? 32'h1 : 32'h3, q);
        n = 0;
        w = 0;
        do begin
            @(posedge core_clk);
            w++;
            if (sys_tick === 1'b1 && cpu_halt === 1'b1) n++;
        end while (conv_done !== 1'b1 && w < 30000);
        if (w >= 30000) n_mismatch++;
        chk("ticks", n, cpc_t[r] * (4 << ck));
        chk("halt", cpu_halt, 1'b0);
        chk("gain", adc_gain_code, a[15:11]);
        chk("clock", adc_clock_code, ck);
        chk("res", adc_resolution_code, r);
        chk("bits", adc_resolution_bits, bits_t[r]);
        chk("cpc", adc_clocks_per_conv, cpc_t[r]);
        chk("group", adc_gain_group, grp(a[15:11]));
        chk("offset", {adc_offset_sign, adc_offset_magnitude}, a[3:0]);
        chk("level", $unsigned(adc_offset_level), lvl(a[3:0]));
        chk("bias", adc_bias_code, b[6:4]);
        chk("ref", {ref_bandgap, ref_external, ref_supply, adc_reference_select},
            {rs[1], rs == 2'h1, rs == 2'h0, rs});
        chk("channel", conv_temp, t);
        @(posedge core_clk);
        chk("done", conv_done, 1'b0);
        acc_cpu_model_i.xfer(1'b0, IDX_START, 32'h0, q);
        chk("start", q, 32'h0);
        acc_cpu_model_i.xfer(1'b0, IDX_STATUS, 32'h0, q);
        chk("status idle", q, {30'h0, t, 1'b0});
    endtask : conv

    // Slow clock code: time the first half period, then cut the run by reset
    task automatic abort(input logic [2:0] ck);
        int n;
        int w;
        acc_cpu_model_i.xfer(1'b1, IDX_CH2_A, {21'h0, ck, 8'h00}, q);
        acc_cpu_model_i.xfer(1'b1, IDX_START, 32'h2, q);
        n = 0;
        w = 0;
        do begin
            @(posedge core_clk);
            w++;
            if (sys_tick === 1'b1 && cpu_halt === 1'b1) n++;
        end while (converter_clock !== 1'b1 && w < 3000);
        if (w >= 3000) n_mismatch++;
        chk("half period", n, (4 << ck) / 2);
        acc_cpu_model_i.xfer(1'b0, IDX_STATUS, 32'h0, q);
        chk("status busy", q, 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("reset outputs", {cpu_halt, converter_clock, conv_done}, 3'h0);
        acc_cpu_model_i.xfer(1'b0, IDX_START, 32'h0, q);
        chk("reset start", q, 32'h0);
        acc_cpu_model_i.xfer(1'b0, IDX_CH2_A, 32'h0, q);
        chk("reset cfg", q, 32'h0);
    endtask : abort

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        regs();
        $display("test registers done");
        for (int i = 0; i < 7; i++) begin
            conv(i, i[0], (i == 0) ? 3'h1 : 3'h0);
            $display("test conversion %0d done", i);
        end
        for (int i = 0; i < 2; i++) begin
            abort(3'(2 + $unsigned($random(seed)) % 6));
            $display("test cut conversion %0d done", i);
        end
        end_of_test();
    end

    initial begin
        #1900000;
        n_mismatch++;
        end_of_test();
    end
endmodule : testbench
